/* pkg/bitbang_defs.vh */
/*
 * Constants for the parallel bit-bang port engine: register offsets,
 * field positions, mode values and reset values.
 * Assumes inclusion by bare name from design files under logic/.
 */
`ifndef BITBANG_DEFS_VH
`define BITBANG_DEFS_VH

////////////////////////////////////////////////////////////////////////
// register map: byte address = {channel, register, 2'b00}
`define BB_ADDR_W        6
`define BB_CH_MSB        5
`define BB_CH_LSB        4
`define BB_REG_MSB       3
`define BB_REG_LSB       2
`define BB_REG_MODE      2'h0
`define BB_REG_DIV       2'h1
`define BB_REG_STAT      2'h2

////////////////////////////////////////////////////////////////////////
// mode register fields: direction mask low byte, mode value next byte
`define BB_DIR_LSB       0
`define BB_MODEV_LSB     8

// port-mode command values
`define BB_MODE_RESET    8'h00
`define BB_MODE_ASYNC    8'h01
`define BB_MODE_SYNC     8'h04

////////////////////////////////////////////////////////////////////////
// reset values
`define BB_DIR_RESET     8'h00
`define BB_DIV_RESET     16'h0009
`define BB_OE_N_IDLE     8'hFF

`endif

/* logic/two_entry_buffer.v */
/*
 * Two-entry buffer with valid/ready on both sides; all outputs are flops.
 * Assumes one clock, synchronous active-low reset.
 */
module two_entry_buffer #(
    parameter W = 8
) (
    input  wire         sys_clk,   // core clock
    input  wire         rst_n,     // sync reset, active low
    input  wire [W-1:0] inData,    // word from producer
    input  wire         inValid,   // producer offers a word
    output wire         inReady,   // room for a word
    output wire [W-1:0] outData,   // head word
    output wire         outValid,  // head word present
    input  wire         outReady   // consumer takes head
);

    reg [W-1:0] d0_q;
    reg [W-1:0] d1_q;
    reg         v0_q;
    reg         v1_q;
    wire        push;
    wire        pop;

    ////////////////////////////////////////////////////////////////////
    // ready from the second slot flop keeps the path short
    assign inReady  = ~v1_q;
    assign outValid = v0_q;
    assign outData  = d0_q;
    assign push     = inValid & ~v1_q;
    assign pop      = v0_q & outReady;

    // slot 0 is always the head
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            v0_q <= 1'b0;
            v1_q <= 1'b0;
            d0_q <= {W{1'b0}};
            d1_q <= {W{1'b0}};
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (!v0_q) begin
                        d0_q <= inData;
                        v0_q <= 1'b1;
                    end else begin
                        d1_q <= inData;
                        v1_q <= 1'b1;
                    end
                end
                2'b01: begin
                    d0_q <= d1_q;
                    v0_q <= v1_q;
                    v1_q <= 1'b0;
                end
                2'b11: begin
                    // push implies slot 1 empty, so new word becomes head
                    d0_q <= inData;
                end
                default: begin
                    v0_q <= v0_q;
                end
            endcase
        end
    end

endmodule

/* logic/bit_bang_engine.v */
/*
 * Multi-channel parallel bit-bang engine: moves host bytes from the
 * receive FIFO onto a byte-wide port and returns pin samples toward the
 * transmit FIFO through a two-entry buffer per channel.
 * Assumes FIFO ports are valid/ready in the sys_clk domain, pins are
 * synchronous to sys_clk, and software uses the plain register port.
 */
// The address map and the plain strobed port were chosen for this implementation.
`include "bitbang_defs.vh"

// Behaviour
// - every channel offers asynchronous and synchronous bit-bang, chosen per channel.
// - asynchronous mode drives host bytes onto output pins without further host action.
// - each pin has its own direction bit.
// - asynchronous output pace comes from the channel baud-rate generator.
// - asynchronous outputs change only on pending byte plus baud tick; else hold.
// - synchronous outputs update only when a host byte is taken from receive FIFO.
// - synchronous pin samples are returned only because an output byte was written.
// - synchronous mode takes no byte unless the sample path has room.
// - pins are sampled before the new output, so returned data lags one byte.
// - the write and read strobes stay internal, never driven on pins.
// - sync order: sample and forward, switch outputs, one setup cycle, strobe.
// - after reset every channel is in serial mode.
// - configuration only enables the RS485 drive output in serial mode.
// - mode state is kept per channel.
module bit_bang_engine #(
    parameter NCH = 4,
    parameter W   = 8
) (
    input  wire                   sys_clk,          // core clock, 20 MHz
    input  wire                   rst_n,            // sync reset, active low
    input  wire [`BB_ADDR_W-1:0]  regAddr,          // register byte address
    input  wire [31:0]            regWrData,        // register write data
    input  wire                   regWr,            // write strobe
    input  wire                   regRd,            // read strobe
    output reg  [31:0]            regRdData,        // read data, cycle after
    input  wire [NCH*W-1:0]       rxData,           // receive FIFO heads
    input  wire [NCH-1:0]         rxValid,          // receive FIFO not empty
    output wire [NCH-1:0]         rxReady,          // pop receive FIFO
    output wire [NCH*W-1:0]       txData,           // pin samples to host
    output wire [NCH-1:0]         txValid,          // sample available
    input  wire [NCH-1:0]         txReady,          // transmit FIFO accepts
    input  wire [NCH*W-1:0]       pinIn,            // port pin levels
    output wire [NCH*W-1:0]       pinOut,           // port pin drive values
    output wire [NCH*W-1:0]       pinOeN,           // low while pin driven
    input  wire [NCH-1:0]         rs485Cfg,         // config memory drive option
    output wire [NCH-1:0]         rs485DriveEnable  // RS485 drive enable
);

    localparam ST_IDLE   = 2'h0;
    localparam ST_APPLY  = 2'h1;
    localparam ST_SETUP  = 2'h2;
    localparam ST_STROBE = 2'h3;

    wire [NCH*32-1:0] modeRd;
    wire [NCH*32-1:0] divRd;
    wire [NCH*32-1:0] statRd;
    reg  [31:0]       rdMux;
    wire [1:0]        rdCh;

    ////////////////////////////////////////////////////////////////////
    // one decode shared by every channel and register
    function regHit;
        input [`BB_ADDR_W-1:0] a;
        input integer          ch;
        input [1:0]            idx;
        begin
            regHit = (a[`BB_CH_MSB:`BB_CH_LSB] == ch) &&
                     (a[`BB_REG_MSB:`BB_REG_LSB] == idx) && (a[1:0] == 2'h0);
        end
    endfunction

    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : chan
            reg  [7:0]  modeQ;
            reg  [W-1:0] dirQ;
            reg  [15:0] divQ;
            reg  [15:0] cntQ;
            reg  [1:0]  stQ;
            reg  [W-1:0] byteQ;
            reg         pendQ;
            reg         rxRdyQ;
            reg  [W-1:0] sampQ;
            reg         pushQ;
            reg  [W-1:0] outQ;
            reg  [W-1:0] oeNQ;
            reg         wrStbNQ;
            reg         rdStbNQ;
            reg         rsQ;
            wire        tick;
            wire        take;
            wire        bufRdy;
            wire        isAsync;
            wire        isSync;
            wire        modeWr;
            wire [W-1:0] rxByte;

            assign rxByte  = rxData[c*W +: W];
            assign isAsync = (modeQ == `BB_MODE_ASYNC);
            assign isSync  = (modeQ == `BB_MODE_SYNC);
            assign tick    = (cntQ == 16'h0000);
            assign take    = rxValid[c] & rxRdyQ;
            assign modeWr  = regWr && regHit(regAddr, c, `BB_REG_MODE);

            ////////////////////////////////////////////////////////////
            // samples queue here so a stalled transmit FIFO loses none
            two_entry_buffer #(
                .W (W)
            ) u_samp (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .inData   (sampQ),
                .inValid  (pushQ),
                .inReady  (bufRdy),
                .outData  (txData[c*W +: W]),
                .outValid (txValid[c]),
                .outReady (txReady[c])
            );

            // register writes, baud generator and mode engine
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    modeQ   <= `BB_MODE_RESET;
                    dirQ    <= `BB_DIR_RESET;
                    divQ    <= `BB_DIV_RESET;
                    cntQ    <= `BB_DIV_RESET;
                    stQ     <= ST_IDLE;
                    byteQ   <= {W{1'b0}};
                    pendQ   <= 1'b0;
                    rxRdyQ  <= 1'b0;
                    sampQ   <= {W{1'b0}};
                    pushQ   <= 1'b0;
                    outQ    <= {W{1'b0}};
                    oeNQ    <= `BB_OE_N_IDLE;
                    wrStbNQ <= 1'b1;
                    rdStbNQ <= 1'b1;
                    rsQ     <= 1'b0;
                end else begin
                    pushQ <= 1'b0;
                    // baud ticks run free in every mode
                    cntQ <= tick ? divQ : cntQ - 16'h0001;
                    if (regWr && regHit(regAddr, c, `BB_REG_DIV)) begin
                        divQ <= regWrData[15:0];
                    end
                    // config memory only reaches the RS485 enable
                    rsQ <= rs485Cfg[c] && (modeQ == `BB_MODE_RESET);
                    // pins driven only in bit-bang, per-bit direction
                    oeNQ <= (isAsync || isSync) ? ~dirQ : `BB_OE_N_IDLE;
                    if (modeWr) begin
                        // a mode change touches this channel only; aborts work
                        modeQ   <= regWrData[`BB_MODEV_LSB +: 8];
                        dirQ    <= regWrData[`BB_DIR_LSB +: W];
                        stQ     <= ST_IDLE;
                        pendQ   <= 1'b0;
                        rxRdyQ  <= 1'b0;
                        wrStbNQ <= 1'b1;
                        rdStbNQ <= 1'b1;
                    end else if (isAsync) begin
                        if (take) begin
                            byteQ  <= rxByte;
                            pendQ  <= 1'b1;
                            rxRdyQ <= 1'b0;
                        end else if (pendQ && tick) begin
                            outQ    <= byteQ;
                            pendQ   <= 1'b0;
                            rxRdyQ  <= 1'b1;
                            wrStbNQ <= 1'b0;
                        end else begin
                            rxRdyQ  <= ~pendQ;
                            wrStbNQ <= 1'b1;
                        end
                    end else if (isSync) begin
                        case (stQ)
                            ST_IDLE: begin
                                wrStbNQ <= 1'b1;
                                if (take) begin
                                    // sample before the new byte is applied
                                    byteQ   <= rxByte;
                                    sampQ   <= pinIn[c*W +: W];
                                    pushQ   <= 1'b1;
                                    rdStbNQ <= 1'b1;
                                    rxRdyQ  <= 1'b0;
                                    stQ     <= ST_APPLY;
                                end else begin
                                    rxRdyQ <= bufRdy;
                                end
                            end
                            ST_APPLY: begin
                                outQ    <= byteQ;
                                rdStbNQ <= 1'b0;
                                stQ     <= ST_SETUP;
                            end
                            ST_SETUP: begin
                                // one cycle of data setup before the strobe
                                wrStbNQ <= 1'b0;
                                stQ     <= ST_STROBE;
                            end
                            ST_STROBE: begin
                                wrStbNQ <= 1'b1;
                                stQ     <= ST_IDLE;
                            end
                            default: begin
                                stQ <= ST_IDLE;
                            end
                        endcase
                    end else begin
                        // serial or unsupported values leave the port idle
                        rxRdyQ  <= 1'b0;
                        pendQ   <= 1'b0;
                        stQ     <= ST_IDLE;
                        wrStbNQ <= 1'b1;
                        rdStbNQ <= 1'b1;
                    end
                end
            end

            ////////////////////////////////////////////////////////////
            // strobes are visible only in status, never on a pin
            assign rxReady[c]          = rxRdyQ;
            assign pinOut[c*W +: W]    = outQ;
            assign pinOeN[c*W +: W]    = oeNQ;
            assign rs485DriveEnable[c] = rsQ;
            assign modeRd[c*32 +: 32]  = {16'h0000, modeQ, dirQ};
            assign divRd[c*32 +: 32]   = {16'h0000, divQ};
            assign statRd[c*32 +: 32]  = {9'h000, rdStbNQ, wrStbNQ, stQ, pendQ,
                                          txValid[c], bufRdy, outQ, pinIn[c*W +: W]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets answer zero
    assign rdCh = regAddr[`BB_CH_MSB:`BB_CH_LSB];

    always @* begin
        rdMux = 32'h00000000;
        if (regAddr[1:0] == 2'h0) begin
            case (regAddr[`BB_REG_MSB:`BB_REG_LSB])
                `BB_REG_MODE: rdMux = modeRd[rdCh*32 +: 32];
                `BB_REG_DIV:  rdMux = divRd[rdCh*32 +: 32];
                `BB_REG_STAT: rdMux = statRd[rdCh*32 +: 32];
                default:      rdMux = 32'h00000000;
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdData <= 32'h00000000;
        end else begin
            regRdData <= regRd ? rdMux : 32'h00000000;
        end
    end

endmodule

/* tb/bit_bang_engine_props.sv */
/* checker: channel 0 bit-bang timing, pin enables, drive enable, read port.
   assumes a bind to bit_bang_engine; channel 0 mode is tracked from writes. */
`include "bitbang_defs.vh"
module bit_bang_engine_props #(
    parameter NCH = 4,
    parameter W   = 8
) (
    input logic                   sys_clk,          // core clock
    input logic                   rst_n,            // sync reset, low
    input logic [`BB_ADDR_W-1:0]  regAddr,          // register address
    input logic [31:0]            regWrData,        // write data
    input logic                   regWr,            // write strobe
    input logic                   regRd,            // read strobe
    input logic [31:0]            regRdData,        // read data
    input logic [NCH*W-1:0]       rxData,           // host bytes
    input logic [NCH-1:0]         rxValid,          // byte offered
    input logic [NCH-1:0]         rxReady,          // byte taken
    input logic [NCH-1:0]         txValid,          // sample offered
    input logic [NCH*W-1:0]       pinOut,           // drive values
    input logic [NCH*W-1:0]       pinOeN,           // low while driven
    input logic [NCH-1:0]         rs485Cfg,         // drive option
    input logic [NCH-1:0]         rs485DriveEnable  // drive enable
);
    logic [7:0] modeQ;
    logic [7:0] dirQ;
    wire        take    = rxValid[0] && rxReady[0];
    wire        syncOn  = modeQ == `BB_MODE_SYNC;
    wire        asyncOn = modeQ == `BB_MODE_ASYNC;

    ////////////////////////////////////////
    // shadow of the channel 0 mode register, same one-cycle effect as the design
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            modeQ <= 8'h00;
            dirQ  <= 8'h00;
        end else if (regWr && regAddr == 6'h00) begin
            modeQ <= regWrData[15:8];
            dirQ  <= regWrData[7:0];
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////
    rd_data_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside its slot");
    // byte is latched at the take edge and reaches the pins one edge later
    sync_pins_a: assert property (syncOn && take && !regWr |->
        ##2 pinOut[7:0] == $past(rxData[7:0], 2))
        else $error("sync byte not on pins");
    sync_hold_a: assert property (syncOn && !take && !regWr |-> ##2 $stable(pinOut[7:0]))
        else $error("sync pins moved without a byte");
    sync_gap_a: assert property (syncOn && take |=> !rxReady[0] [*4])
        else $error("sync cycle too short");
    // push flop plus buffer slot put two edges between take and txValid
    sample_cause_a: assert property (syncOn && $rose(txValid[0]) |-> $past(take, 2))
        else $error("sample without output byte");
    async_hold_a: assert property (asyncOn && rxReady[0] && !regWr |=> $stable(pinOut[7:0]))
        else $error("async pins moved without pending byte");
    drive_enable_a: assert property ($past(rst_n) |->
        rs485DriveEnable[0] == $past(rs485Cfg[0] && modeQ == `BB_MODE_RESET))
        else $error("drive enable wrong");
    pin_dir_a: assert property ($past(rst_n) |->
        pinOeN[7:0] == ($past(syncOn || asyncOn) ? ~$past(dirQ) : 8'hFF))
        else $error("pin enables wrong");

    cover property (syncOn && take);
    cover property (asyncOn && take);
    cover property (syncOn && $rose(txValid[0]));
endmodule

bind bit_bang_engine bit_bang_engine_props #(.NCH(NCH), .W(W)) bit_bang_engine_props_i (
    .sys_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxData,
    .rxValid, .rxReady, .txValid, .pinOut, .pinOeN, .rs485Cfg, .rs485DriveEnable);

/* tb/pin_world.sv */
/* far side of the port: pins either follow the engine's drive or show
   the outside level. assumes pinOeN low means the engine drives. */
module pin_world #(
    parameter NCH = 4,
    parameter W   = 8
) (
    input  logic [NCH*W-1:0] pinOut,   // engine drive values
    input  logic [NCH*W-1:0] pinOeN,   // low while driven
    input  logic [NCH*W-1:0] extLevel, // outside world level
    output logic [NCH*W-1:0] pinIn     // resolved pin level
);
    // a released pin shows the outside level, never the last drive value
    assign pinIn = (pinOut & ~pinOeN) | (extLevel & pinOeN);
endmodule

/* tb/bit_bang_engine_test.sv */
/* self-checking bench for the bit-bang engine, random bytes from a fixed seed.
   assumes pin_world as far side and the checker bound to the engine. */
`include "bitbang_defs.vh"
module bit_bang_engine_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 0, rst_n = 0, regWr = 0, regRd = 0;
    logic [5:0]  regAddr = 0;
    logic [31:0] regWrData = 0, regRdData, rxData = 0, txData, pinIn, pinOut, pinOeN;
    logic [31:0] extLevel = 0, rv;
    logic [3:0]  rxValid = 0, rxReady, txValid, txReady = 4'hF, rs485Cfg = 0, rs485DriveEnable;
    logic [9:0]  got[$], want[$];
    logic [7:0]  b, d, prev;
    int          fail_count = 0, checks_done = 0, n;

    bit_bang_engine #(.NCH(4), .W(8)) bit_bang_engine_i (.sys_clk, .rst_n, .regAddr,
        .regWrData, .regWr, .regRd, .regRdData, .rxData, .rxValid, .rxReady, .txData,
        .txValid, .txReady, .pinIn, .pinOut, .pinOeN, .rs485Cfg, .rs485DriveEnable);
    pin_world #(.NCH(4), .W(8)) pin_world_i (.pinOut, .pinOeN, .extLevel, .pinIn);

    always #25 sys_clk = ~sys_clk;

    // every sample accepted by the host side, tagged with its channel
    always @(posedge sys_clk)
        for (int c = 0; c < 4; c++)
            if (rst_n && txValid[c] && txReady[c]) got.push_back({c[1:0], txData[8*c +: 8]});

    ////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
        checks_done++;
        if (g !== e) begin
            $display("Error at %0t: %s got %h want %h", $time, what, g, e);
            fail_count++;
        end
    endtask
    task automatic wr(input int ch, input logic [1:0] r, input logic [31:0] v);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= {ch[1:0], r, 2'b00};
        regWrData <= v;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input int ch, input logic [1:0] r, output logic [31:0] v);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= {ch[1:0], r, 2'b00};
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask
    // offer one byte; waited is -1 when it was never taken
    task automatic send(input int ch, input logic [7:0] v, input int bound, output int waited);
        @(posedge sys_clk);
        rxData[8*ch +: 8] <= v;
        rxValid[ch] <= 1'b1;
        waited = 0;
        do begin
            @(posedge sys_clk);
            waited++;
        end while (rxReady[ch] !== 1'b1 && waited < bound);
        rxValid[ch] <= 1'b0;
        if (rxReady[ch] !== 1'b1) waited = -1;
    endtask
    task automatic wait_q(input int k);
        for (int i = 0; i < 200 && got.size() < k; i++) @(posedge sys_clk);
        check(got.size(), k, "sample count");
    endtask
    function automatic logic [7:0] pins(input logic [7:0] o, input logic [7:0] dir,
                                        input logic [7:0] ext);
        return (o & dir) | (ext & ~dir);
    endfunction
    task automatic give_verdict;
        $display("checks %0d, errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////
    // watchdog in case a handshake hangs outside the bounded loops
    initial begin
        #2ms;
        fail_count++;
        give_verdict();
    end

    initial begin
        rv = $urandom(49153);
        rs485Cfg <= 4'($urandom);
        extLevel <= $urandom;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            rd(c, `BB_REG_MODE, rv);
            check(rv, 32'h0, "mode at reset");
            rd(c, `BB_REG_DIV, rv);
            check(rv, {16'h0, `BB_DIV_RESET}, "divisor at reset");
            rd(c, 2'h3, rv);
            check(rv, 32'h0, "unmapped read");
        end
        check(pinOeN, 32'hFFFFFFFF, "pins released at reset");
        check(rs485DriveEnable, rs485Cfg, "drive enable in serial");
        // sync on channel 1 with the host side stalled
        txReady[1] <= 1'b0;
        wr(1, `BB_REG_MODE, {16'h0, `BB_MODE_SYNC, 8'hFF});
        repeat (2) @(posedge sys_clk);
        check(pinOeN[15:8], 8'h00, "sync pins driven");
        check(rs485DriveEnable, rs485Cfg & 4'hD, "others stay serial");
        rd(0, `BB_REG_MODE, rv);
        check(rv, 32'h0, "channel 0 untouched");
        send(1, 8'h55, 20, n);
        check(n > 0, 1, "first byte taken");
        send(1, 8'hAA, 20, n);
        check(n > 0, 1, "second byte taken");
        b = $urandom;
        send(1, b, 40, n);
        check(n, -1, "byte refused while samples full");
        txReady[1] <= 1'b1;
        send(1, b, 40, n);
        check(n > 0, 1, "byte taken after drain");
        wait_q(3);
        repeat (20) @(posedge sys_clk);
        check(got.size(), 3, "one sample per byte");
        check({got[0], got[1], got[2]}, {10'h100, 10'h155, 10'h1AA}, "samples lag");
        check(pinOut[15:8], b, "last byte on pins");
        // random sync traffic on channel 0 with a random direction mask
        got.delete();
        d = $urandom;
        prev = 8'h00;
        wr(0, `BB_REG_MODE, {16'h0, `BB_MODE_SYNC, d});
        for (int i = 0; i < 8; i++) begin
            b = $urandom;
            send(0, b, 20, n);
            want.push_back({2'd0, pins(prev, d, extLevel[7:0])});
            prev = b;
        end
        wait_q(8);
        for (int i = 0; i < 8; i++) check(got[i], want[i], "sync sample");
        // async on channel 0, paced by a small divisor
        got.delete();
        d = 8'($urandom_range(4, 1));
        wr(0, `BB_REG_DIV, {24'h0, d});
        // let the count left from the reset divisor run out first
        repeat (12) @(posedge sys_clk);
        wr(0, `BB_REG_MODE, {16'h0, `BB_MODE_ASYNC, 8'h0F});
        b = ~prev;
        send(0, b, 3 * d + 10, n);
        for (n = 0; n <= d + 2 && pinOut[7:0] !== b; n++) @(posedge sys_clk);
        check(pinOut[7:0], b, "async byte within a tick");
        repeat (3 * d + 3) @(posedge sys_clk);
        check(pinOut[7:0], b, "pins hold last byte");
        check(pinOeN[7:0], 8'hF0, "only masked pins driven");
        rd(0, `BB_REG_STAT, rv);
        check(rv[7:0], pins(b, 8'h0F, extLevel[7:0]), "pin levels");
        check(got.size(), 0, "async returns no samples");
        // back to serial, and an unknown mode value
        wr(0, `BB_REG_MODE, {16'h0, `BB_MODE_RESET, 8'hFF});
        wr(3, `BB_REG_MODE, {16'h0, 8'h02, 8'hFF});
        rxValid[0] <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check(rxReady[0], 1'b0, "serial takes no byte");
        rxValid[0] <= 1'b0;
        check({pinOeN[31:24], pinOeN[7:0]}, 16'hFFFF, "pins released");
        check(rs485DriveEnable[0], rs485Cfg[0], "drive enable back");
        // second reset while channel 1 is still in sync
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(1, `BB_REG_MODE, rv);
        check(rv, 32'h0, "mode cleared by reset");
        check(pinOeN, 32'hFFFFFFFF, "pins released by reset");
        wr(1, `BB_REG_MODE, {16'h0, `BB_MODE_SYNC, 8'h3C});
        rd(1, `BB_REG_MODE, rv);
        check(rv, {16'h0, `BB_MODE_SYNC, 8'h3C}, "mode reissued");
        give_verdict();
    end
endmodule
